/* hw/lbk_consts.svh */
// Constants for the loopback, reference and lock control block.
// Assumes a 50 MHz core clock; included by bare name.
`ifndef LBK_CONSTS_SVH
`define LBK_CONSTS_SVH
`define CLK_PERIOD_NS 20
`define RESET_MIN_NS 1000
`define RESET_MIN_CYC ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REF_TMO_CYC 32
`define CAL_EDGES 64
`define RX_ACQ_EDGES 32
`define RX_TMO_CYC 32
// Pin index within the control pin vector
`define PIN_NEAR 0
`define PIN_FAR 1
`define PIN_REF_SOURCE_SELECT 2
`define PIN_RATE 3
`define PIN_WIDTH 4
`define PIN_SQL 5
`define PIN_N 6
// Pull levels: loopbacks and squelch up, selects down, 16-bit mode up
`define PIN_DEFAULTS 6'h33
`define RATIO_REF16 6'h10
`define RATIO_REF32 6'h20
`define RATIO_W4 6'h04
`define RATIO_W16 6'h10
`define ADDR_CTRL 4'h0
`define ADDR_STATUS 4'h4
`define ADDR_RATIO 4'h8
`define CTRL_RESET 6'h3f
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* hw/lbk_pkg.sv */
// Types for the loopback, reference and lock control block.
// Assumes nothing beyond a SystemVerilog compiler.
package lbk_pkg;
  typedef struct packed {
    logic clk;
    logic dat;
  } serial_pair_t;
  typedef enum logic [1:0] {ST_NOREF, ST_CAL, ST_LOCK} lock_state_t;
endpackage

/* hw/lbk_ctrl.sv */
// Loopback routing, reference selection, lock indication and reset
// recentering for a serial transceiver, with an AXI4-Lite register slave.
// Assumes serializer and recovery streams come from core_clk logic; pins
// and reference clocks are asynchronous and are synchronised here.
//
// Contract
// RQ1: Near loopback low routes serializer into deserializer
// RQ2: Party never drives both loopbacks low
// RQ3: Far loopback low forwards recovered stream out
// RQ4: Select high uses dedicated reference, else parallel
// RQ5: Rate select picks sixteenth or thirty-second ratio
// RQ6: Parallel clock is quarter or sixteenth rate
// RQ7: Parallel reference ignores the rate select
// RQ8: Multiplier raises selected reference to bit rate
// RQ9: Transmit lock output high once multiplier locked
// RQ10: Recovery loop precentered from selected reference
// RQ11: Receive lock output high once recovery locked
// RQ12: Reset held low at least one microsecond; here sys_rst_i is active high and the bench first holds it 12 cycles
// RQ13: Reset recenters FIFO pointers, clears control state
// RQ14: Reset release starts multiplier calibration
// RQ15: Unconnected control inputs take defined defaults
// RQ16: Transmit lock low during calibration or no reference
// RQ17: Recenter FIFO on each transmit lock rise
// RQ18: Far loopback ignores transmit squelch
// RQ19: Near loopback drives receive data and clocks
// RQ20: Synchronise static control inputs before use
`include "lbk_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module lbk_ctrl #(
  parameter int CAL_EDGES = `CAL_EDGES,
  parameter int RX_ACQ    = `RX_ACQ_EDGES
) (
  input  wire logic                 core_clk_i,
  input  wire logic                 sys_rst_i,
  input  wire logic                 near_loopback_n_i,
  input  wire logic                 far_loopback_n_i,
  input  wire logic                 ref_source_select_i,
  input  wire logic                 ref_rate_select_i,
  input  wire logic                 word_width_select_i,
  input  wire logic                 tx_squelch_n_i,
  input  wire logic                 dedicated_ref_clock_i,
  input  wire logic                 parallel_tx_clock_in_i,
  input  wire lbk_pkg::serial_pair_t serializer_i,
  input  wire lbk_pkg::serial_pair_t serial_rx_input_i,
  output var  lbk_pkg::serial_pair_t deserializer_o,
  output var  lbk_pkg::serial_pair_t serial_tx_output_o,
  output logic                      rx_clock_out_a_o,
  output logic                      rx_clock_out_b_o,
  output logic [5:0]                mult_ratio_o,
  output logic                      rx_precenter_o,
  output logic                      tx_lock_lost_n_o,
  output logic                      rx_lock_lost_n_o,
  output logic                      fifo_recenter_o,
  input  wire logic [3:0]           awaddr_i,
  input  wire logic                 awvalid_i,
  output logic                      awready_o,
  input  wire logic [31:0]          wdata_i,
  input  wire logic [3:0]           wstrb_i,
  input  wire logic                 wvalid_i,
  output logic                      wready_o,
  output logic [1:0]                bresp_o,
  output logic                      bvalid_o,
  input  wire logic                 bready_i,
  input  wire logic [3:0]           araddr_i,
  input  wire logic                 arvalid_i,
  output logic                      arready_o,
  output logic [31:0]               rdata_o,
  output logic [1:0]                rresp_o,
  output logic                      rvalid_o,
  input  wire logic                 rready_i
);
  import lbk_pkg::*;

  localparam int NS = `PIN_N + 4;
  logic [NS-1:0]     s1_r;
  logic [NS-1:0]     s2_r;
  logic [NS-1:0]     s3_r;
  logic [`PIN_N-1:0] conn_r;
  logic [`PIN_N-1:0] pin;
  logic              ref_edge;
  logic              rec_edge;
  logic              ref_source_select_prev_r;
  logic [5:0]        ref_tmo_r;
  logic              ref_ok;
  logic [6:0]        cal_cnt_r;
  lock_state_t       st_r;
  logic [5:0]        rx_cnt_r;
  logic [5:0]        rx_tmo_r;
  logic              illegal;
  serial_pair_t      rec;

  // RQ20 two-flop sync
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      // Pins idle at their pull levels
      s1_r <= {4'h0, `PIN_DEFAULTS};
      s2_r <= {4'h0, `PIN_DEFAULTS};
      s3_r <= {4'h0, `PIN_DEFAULTS};
    end else begin
      s1_r <= {serial_rx_input_i.dat, serial_rx_input_i.clk, parallel_tx_clock_in_i,
               dedicated_ref_clock_i, tx_squelch_n_i, word_width_select_i,
               ref_rate_select_i, ref_source_select_i, far_loopback_n_i,
               near_loopback_n_i};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // RQ15 pull defaults
  assign pin = (s2_r[`PIN_N-1:0] & conn_r) | (`PIN_DEFAULTS & ~conn_r);
  assign rec.clk = s2_r[`PIN_N+2];
  assign rec.dat = s2_r[`PIN_N+3];
  assign illegal = ~pin[`PIN_NEAR] & ~pin[`PIN_FAR];

  // RQ4 reference choice
  assign ref_edge = pin[`PIN_REF_SOURCE_SELECT] ? (s2_r[`PIN_N] & ~s3_r[`PIN_N])
                                     : (s2_r[`PIN_N+1] & ~s3_r[`PIN_N+1]);
  assign rec_edge = s2_r[`PIN_N+2] & ~s3_r[`PIN_N+2];
  assign ref_ok   = ref_tmo_r < 6'(`REF_TMO_CYC);

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ref_tmo_r <= 6'(`REF_TMO_CYC);
    end else if (ref_edge) begin
      ref_tmo_r <= '0;
    end else if (ref_ok) begin
      ref_tmo_r <= ref_tmo_r + 6'h01;
    end
  end

  // RQ13 RQ14 RQ16 calibration and lock
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r          <= ST_CAL;
      cal_cnt_r     <= '0;
      ref_source_select_prev_r <= 1'b0;
    end else begin
      ref_source_select_prev_r <= pin[`PIN_REF_SOURCE_SELECT];
      if (!ref_ok) begin
        st_r      <= ST_NOREF;
        cal_cnt_r <= '0;
      end else if (ref_source_select_prev_r != pin[`PIN_REF_SOURCE_SELECT] || st_r == ST_NOREF) begin
        st_r      <= ST_CAL;
        cal_cnt_r <= '0;
      end else if (st_r == ST_CAL && ref_edge) begin
        if (cal_cnt_r == 7'(CAL_EDGES - 1)) begin
          st_r <= ST_LOCK;
        end
        cal_cnt_r <= cal_cnt_r + 7'h01;
      end
    end
  end

  // RQ11 receive lock after enough recovered edges
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_cnt_r <= '0;
      rx_tmo_r <= '0;
    end else begin
      rx_tmo_r <= rec_edge ? 6'h00 : (rx_tmo_r == 6'(`RX_TMO_CYC) ? rx_tmo_r
                                                              : rx_tmo_r + 6'h01);
      // RQ10 acquire only when precentered
      if (!ref_ok || rx_tmo_r == 6'(`RX_TMO_CYC)) begin
        rx_cnt_r <= '0;
      end else if (rec_edge && rx_cnt_r != 6'(RX_ACQ)) begin
        rx_cnt_r <= rx_cnt_r + 6'h01;
      end
    end
  end

  // RQ9 RQ11 RQ17 lock outputs and recenter
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_lock_lost_n_o <= 1'b0;
      rx_lock_lost_n_o <= 1'b0;
      fifo_recenter_o  <= 1'b1;
      rx_precenter_o   <= 1'b0;
    end else begin
      tx_lock_lost_n_o <= st_r == ST_LOCK;
      rx_lock_lost_n_o <= rx_cnt_r == 6'(RX_ACQ);
      fifo_recenter_o  <= st_r == ST_LOCK && !tx_lock_lost_n_o;
      rx_precenter_o   <= ref_ok;
    end
  end

  // RQ5 RQ6 RQ7 RQ8 multiplier ratio
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mult_ratio_o <= `RATIO_W16;
    end else if (pin[`PIN_REF_SOURCE_SELECT]) begin
      mult_ratio_o <= pin[`PIN_RATE] ? `RATIO_REF32 : `RATIO_REF16;
    end else begin
      mult_ratio_o <= pin[`PIN_WIDTH] ? `RATIO_W16 : `RATIO_W4;
    end
  end

  // RQ1 RQ3 RQ18 RQ19 loopback routing
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      deserializer_o     <= '0;
      serial_tx_output_o <= '0;
      rx_clock_out_a_o   <= 1'b0;
      rx_clock_out_b_o   <= 1'b0;
    end else begin
      deserializer_o   <= pin[`PIN_NEAR] ? rec : serializer_i;
      rx_clock_out_a_o <= pin[`PIN_NEAR] ? rec.clk : serializer_i.clk;
      rx_clock_out_b_o <= pin[`PIN_NEAR] ? rec.clk : serializer_i.clk;
      if (!pin[`PIN_FAR]) begin
        serial_tx_output_o <= rec;
      end else begin
        serial_tx_output_o.clk <= serializer_i.clk;
        serial_tx_output_o.dat <= serializer_i.dat & pin[`PIN_SQL];
      end
    end
  end

  // Register slave
  logic       aw_hold_r;
  logic       w_hold_r;
  logic [3:0] aw_addr_r;
  logic       wr_go;
  assign awready_o = ~aw_hold_r & ~bvalid_o;
  assign wready_o  = ~w_hold_r & ~bvalid_o;
  assign wr_go     = aw_hold_r & w_hold_r & ~bvalid_o;
  assign arready_o = ~rvalid_o;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_addr_r <= '0;
      bvalid_o  <= 1'b0;
      bresp_o   <= `RESP_OKAY;
      conn_r    <= `CTRL_RESET;
    end else begin
      if (awvalid_i && awready_o) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= awaddr_i;
      end
      if (wvalid_i && wready_o) begin
        w_hold_r <= 1'b1;
        if (wstrb_i[0]) conn_r <= wdata_i[`PIN_N-1:0];
      end
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_o  <= 1'b1;
        bresp_o   <= aw_addr_r == `ADDR_CTRL ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_o && bready_i) begin
        bvalid_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rvalid_o <= 1'b0;
      rdata_o  <= '0;
      rresp_o  <= `RESP_OKAY;
    end else if (arvalid_i && arready_o) begin
      rvalid_o <= 1'b1;
      rresp_o  <= `RESP_OKAY;
      unique case (araddr_i)
        `ADDR_CTRL:   rdata_o <= {26'h0, conn_r};
        `ADDR_STATUS: rdata_o <= {20'h0, pin, st_r, illegal, ref_ok,
                                  rx_lock_lost_n_o, tx_lock_lost_n_o};
        `ADDR_RATIO:  rdata_o <= {26'h0, mult_ratio_o};
        default: begin
          rdata_o <= '0;
          rresp_o <= `RESP_SLVERR;
        end
      endcase
    end else if (rvalid_o && rready_i) begin
      rvalid_o <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence cal_run;
    st_r == ST_CAL ##1 st_r == ST_LOCK;
  endsequence

  a_tx_lock_cal: assert property ($rose(tx_lock_lost_n_o) |-> // RQ16
                                  $past(st_r == ST_LOCK) && $past(st_r == ST_CAL, 2))
    else $error("transmit lock rose without calibration");
  a_cal_lock: assert property (cal_run |=> $rose(tx_lock_lost_n_o)) // RQ9
    else $error("transmit lock not raised after calibration");
  a_tx_low_noref: assert property (!ref_ok |=> ##1 !tx_lock_lost_n_o) // RQ16
    else $error("transmit lock high without reference");
  a_recenter_rise: assert property ($rose(tx_lock_lost_n_o) |-> fifo_recenter_o) // RQ17
    else $error("no recenter on lock rise");
  a_near_route: assert property (!pin[`PIN_NEAR] |=> // RQ1
                                 deserializer_o == $past(serializer_i)
                                 && rx_clock_out_a_o == $past(serializer_i.clk)
                                 && rx_clock_out_b_o == $past(serializer_i.clk))
    else $error("near loopback path wrong");
  a_far_route: assert property (!pin[`PIN_FAR] |=> serial_tx_output_o == $past(rec)) // RQ3
    else $error("far loopback path wrong");
  a_squelch_zero: assert property (pin[`PIN_FAR] && !pin[`PIN_SQL] |=> // RQ18
                                   !serial_tx_output_o.dat)
    else $error("squelch not applied");
  a_ratio_parallel: assert property (!pin[`PIN_REF_SOURCE_SELECT] && !pin[`PIN_WIDTH] |=> // RQ7
                                     mult_ratio_o == `RATIO_W4)
    else $error("parallel reference ratio wrong");
  a_rx_needs_ref: assert property (rx_lock_lost_n_o |-> $past(ref_ok, 2)) // RQ10
    else $error("receive lock without precentering");
endmodule // lbk_ctrl
`default_nettype wire

/* bench/framer_model.sv */
// Framer model: parallel transmit clock and serializer stream.
// Assumes the bench clock and an active-high reset.
`timescale 1ns/10ps
`default_nettype none
module framer_model (
  input  wire logic                  core_clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  word_width_select_i,
  input  wire logic                  hold_i,
  output logic                       parallel_tx_clock_o,
  output var  lbk_pkg::serial_pair_t serializer_o
);
  import lbk_pkg::*;
  logic [3:0] div_r;
  assign parallel_tx_clock_o = word_width_select_i ? div_r[3] : div_r[1];
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_r <= 4'h0;
      serializer_o <= '0;
    end else begin
      div_r <= div_r + 4'h1;
      if (!hold_i) serializer_o <= {~serializer_o.clk, 1'($urandom)};
    end
  end
endmodule // framer_model
`default_nettype wire

/* bench/loopback_dedicated_ref_clock_reset_control_tb_top.sv */
// Bench top: control block against framer model, reference and rx stream.
// Assumes a 50 MHz clock and active-high asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
`include "lbk_consts.svh"
module loopback_dedicated_ref_clock_reset_control_tb_top;
  import lbk_pkg::*;
  logic clk = 0, rst = 1, near_n = 1, far_n = 1, sel = 1, rate = 0, wid = 1, sql_n = 1;
  logic refc = 0, ref_run = 1, rx_run = 0, hold = 0, ptx;
  logic [3:0] rx_cnt = 0;
  serial_pair_t ser, des, stx, rx_in = '0, rx_hold = '0;
  logic rxa, rxb, pre, txl, rxl, frc, awr, wr, bv, arr, rv;
  logic [5:0] ratio;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, d, wdata = 0;
  logic [3:0] awaddr = 0, araddr = 0, wstrb = 0;
  logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  int err_count = 0, n_checks = 0, i;
  initial begin
    forever #10 clk = ~clk;
  end
  initial begin
    #7;
    forever #80 if (ref_run) refc = ~refc;
  end
  always @(posedge clk) begin
    rx_cnt <= rx_cnt + 4'h1;
    rx_in <= rx_run ? {rx_cnt[1], rx_cnt[3]} : rx_hold;
  end
  framer_model FRM (.core_clk_i(clk), .sys_rst_i(rst), .word_width_select_i(wid),
    .hold_i(hold), .parallel_tx_clock_o(ptx), .serializer_o(ser));
  lbk_ctrl #(.CAL_EDGES(4), .RX_ACQ(4)) DUT (.core_clk_i(clk), .sys_rst_i(rst),
    .near_loopback_n_i(near_n), .far_loopback_n_i(far_n), .ref_source_select_i(sel),
    .ref_rate_select_i(rate), .word_width_select_i(wid), .tx_squelch_n_i(sql_n),
    .dedicated_ref_clock_i(refc), .parallel_tx_clock_in_i(ptx), .serializer_i(ser),
    .serial_rx_input_i(rx_in), .deserializer_o(des), .serial_tx_output_o(stx),
    .rx_clock_out_a_o(rxa), .rx_clock_out_b_o(rxb), .mult_ratio_o(ratio),
    .rx_precenter_o(pre), .tx_lock_lost_n_o(txl), .rx_lock_lost_n_o(rxl),
    .fifo_recenter_o(frc), .awaddr_i(awaddr), .awvalid_i(awv), .awready_o(awr),
    .wdata_i(wdata), .wstrb_i(wstrb), .wvalid_i(wv), .wready_o(wr), .bresp_o(bresp),
    .bvalid_o(bv), .bready_i(bready), .araddr_i(araddr), .arvalid_i(arv),
    .arready_o(arr), .rdata_o(rdata), .rresp_o(rresp), .rvalid_o(rv), .rready_i(rready));
  task automatic conclude;
    if (err_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic tmo(input string m);
    chk(0, 1, m);
    conclude();
  endtask
  function automatic logic [5:0] exp_ratio(input logic s, r, w);
    if (s) return r ? `RATIO_REF32 : `RATIO_REF16;
    return w ? `RATIO_W16 : `RATIO_W4;
  endfunction
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
    int n;
    @(posedge clk);
    awaddr <= a; wdata <= v; wstrb <= 4'hf; awv <= 1; wv <= 1; bready <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wr) wv <= 0;
      if (bv) begin
        resp = bresp;
        break;
      end
    end
    bready <= 0;
    if (n == 50) tmo("write hang");
  endtask
  task automatic axi_rd(input logic [3:0] a);
    int n;
    @(posedge clk);
    araddr <= a; arv <= 1; rready <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arr) arv <= 0;
      if (rv) begin
        d = rdata;
        resp = rresp;
        break;
      end
    end
    rready <= 0;
    if (n == 50) tmo("read hang");
  endtask
  task automatic wait_lock;
    int n;
    for (n = 0; n < 600; n++) begin
      @(posedge clk);
      if (txl === 1'b1) break;
    end
    if (n == 600) tmo("no tx lock");
    chk(frc, 1, "no recenter at lock");
  endtask
  initial begin
    void'($urandom(48));
    repeat (12) @(posedge clk);
    chk(frc, 1, "recenter in reset");
    chk(txl, 0, "lock in reset");
    rst <= 0;
    wait_lock();
    axi_rd(`ADDR_CTRL);
    chk(d, 32'h3f, "ctrl reset value");
    axi_rd(4'hc);
    chk(resp, `RESP_SLVERR, "unmapped resp");
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      {sel, rate, wid} <= {~i[2], i[1:0]};
      repeat (6) @(posedge clk);
      chk(ratio, exp_ratio(sel, rate, wid), "ratio pin");
      axi_rd(`ADDR_RATIO);
      chk(d[5:0], exp_ratio(sel, rate, wid), "ratio reg");
    end
    @(posedge clk);
    sel <= 1;
    rate <= 0;
    repeat (6) @(posedge clk);
    wait_lock();
    rx_run <= 1;
    for (i = 0; i < 600; i++) begin
      @(posedge clk);
      if (rxl === 1'b1) break;
    end
    if (i == 600) tmo("no rx lock");
    chk(pre, 1, "precenter");
    near_n <= 0;
    repeat (4) begin
      @(posedge clk);
      hold <= 0;
      @(posedge clk);
      hold <= 1;
      repeat (5) @(posedge clk);
      chk(des, ser, "near data");
      chk({rxa, rxb}, {2{ser.clk}}, "near clocks");
    end
    near_n <= 1;
    sql_n <= 0;
    repeat (6) @(posedge clk);
    chk(stx.dat, 0, "squelch outside far");
    far_n <= 0;
    rx_run <= 0;
    repeat (4) begin
      rx_hold <= 2'($urandom);
      repeat (6) @(posedge clk);
      chk(stx, rx_hold, "far path");
    end
    far_n <= 1;
    sql_n <= 1;
    axi_wr(`ADDR_CTRL, 32'h0);
    chk(resp, `RESP_OKAY, "write resp");
    repeat (5) @(posedge clk);
    axi_rd(`ADDR_STATUS);
    // Far loopback pin pulls up like near
    chk(d[11:6], 6'h33, "pull defaults");
    axi_wr(`ADDR_CTRL, 32'h3f);
    chk(resp, `RESP_OKAY, "write resp");
    repeat (6) @(posedge clk);
    wait_lock();
    ref_run <= 0;
    for (i = 0; i < 200; i++) begin
      @(posedge clk);
      if (txl === 1'b0) break;
    end
    if (i == 200) tmo("lock kept");
    ref_run <= 1;
    wait_lock();
    rst <= 1;
    repeat (50) @(posedge clk);
    chk(frc, 1, "recenter mid reset");
    rst <= 0;
    wait_lock();
    conclude();
  end
endmodule // loopback_dedicated_ref_clock_reset_control_tb_top
`default_nettype wire
